// ---- hw/rpcbl_cyc_engine.sv ----
module rpcbl_cyc_engine #(
  parameter int AW = 23
) (
  input wire logic clk,
  input wire logic rstn,
  rpcbl_cyc_if.engine bus,
  input wire logic [15:0] dqIn,
  output logic [AW-1:0] addr,
  output logic [15:0] dqOut,
  output logic dqOe,
  output logic ceN,
  output logic oeN,
  output logic weN
);
  typedef struct packed {
    rpcbl_pkg::rpcbl_eng_e st;
    logic [7:0] cnt;
    logic [AW-1:0] addr;
    logic [15:0] dq;
    logic dqOe, ceN, oeN, weN, done;
    logic [15:0] rdata;
  } rpcbl_eng_s;

  rpcbl_eng_s s;
  rpcbl_eng_s n;

  // One pin cycle: address setup, strobe low for the timed count, then a
  // hold cycle so data and address outlive the rising strobe.
  always_comb begin
    n = s;
    n.done = 1'b0;
    unique case (s.st)
      rpcbl_pkg::E_IDLE: begin
        n.dqOe = 1'b0;
        // The done guard stops a request still high from restarting.
        if (bus.req && !s.done) begin
          n.st = rpcbl_pkg::E_SET;
          n.addr = bus.addr;
          n.dq = bus.wdata;
          n.dqOe = bus.we;
          n.ceN = 1'b0;
        end
      end
      rpcbl_pkg::E_SET: begin
        n.st = rpcbl_pkg::E_STB;
        n.weN = !bus.we;
        n.oeN = bus.we;
        n.cnt = bus.we ? 8'(rpcbl_pkg::WE_CYC) : 8'(rpcbl_pkg::RD_CYC);
      end
      rpcbl_pkg::E_STB: begin
        n.cnt = s.cnt - 8'h01;
        if (s.cnt == 8'h01) begin
          n.st = rpcbl_pkg::E_HOLD;
          n.weN = 1'b1;
          n.oeN = 1'b1;
          if (!bus.we) n.rdata = dqIn;
        end
      end
      rpcbl_pkg::E_HOLD: begin
        n.st = rpcbl_pkg::E_IDLE;
        n.ceN = 1'b1;
        n.done = 1'b1;
      end
      default: n.st = rpcbl_pkg::E_IDLE;
    endcase
  end

  // All pin outputs come from this register, so they never glitch.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.ceN <= 1'b1;
      s.oeN <= 1'b1;
      s.weN <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign bus.done = s.done;
  assign bus.rdata = s.rdata;
  assign addr = s.addr;
  assign dqOut = s.dq;
  assign dqOe = s.dqOe;
  assign ceN = s.ceN;
  assign oeN = s.oeN;
  assign weN = s.weN;
endmodule

// ---- hw/rpcbl_cyc_if.sv ----
interface rpcbl_cyc_if #(
  parameter int AW = 23
);
  logic req;
  logic we;
  logic [AW-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;

  modport master(output req, output we, output addr, output wdata,
                 input rdata, input done);
  modport engine(input req, input we, input addr, input wdata,
                 output rdata, output done);
endinterface

// ---- hw/rpcbl_host.sv ----
module rpcbl_host #(
  parameter int AW = 23,
  parameter int BLK_SHIFT = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [AW-1:0] flashAddr,
  input wire logic [15:0] flashDqIn,
  output logic [15:0] flashDqOut,
  output logic flashDqOe,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic resetPinLowN,
  input wire logic readyStatusPin
);
  localparam int BLK_W = AW - BLK_SHIFT;

  typedef struct packed {
    rpcbl_pkg::rpcbl_st_e st;
    rpcbl_pkg::rpcbl_op_e op;
    logic [7:0] code;
    logic [BLK_W-1:0] blk;
    logic [7:0] lastSr;
    logic [1:0] mode;
    logic refused, progErr, eraseErr, locked, pulseSeen, cmdReject;
    logic [7:0] pulseWidth;
    logic req, we;
    logic [AW-1:0] addr;
    logic [15:0] wdata;
    logic [7:0] cnt;
    logic ack;
    logic [31:0] dat;
    logic rpN;
  } rpcbl_top_s;

  rpcbl_top_s s;
  rpcbl_top_s n;

  rpcbl_cyc_if #(.AW(AW)) cycBus();

  logic pulseEvt;
  logic [7:0] lowWidth;

  // First word address of a block.
  function automatic logic [AW-1:0] blkBase(input logic [BLK_W-1:0] b);
    return {b, {BLK_SHIFT{1'b0}}};
  endfunction

  // Keeps only the byte lanes that the bus selects.
  function automatic logic [31:0] lanes(input logic [31:0] d,
                                        input logic [3:0] sel);
    return d & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Software view of the controller and of the last flash status byte.
  function automatic logic [31:0] statWord(input rpcbl_top_s t,
                                           input logic pin);
    logic [31:0] w;
    w = 32'h0;
    w[rpcbl_pkg::ST_BUSY] = (t.st != rpcbl_pkg::S_IDLE);
    w[rpcbl_pkg::ST_LOCKED] = t.locked;
    w[rpcbl_pkg::ST_REFUSED] = t.refused;
    w[rpcbl_pkg::ST_PROG_ERR] = t.progErr;
    w[rpcbl_pkg::ST_ERASE_ERR] = t.eraseErr;
    w[rpcbl_pkg::ST_PULSE] = t.pulseSeen;
    w[rpcbl_pkg::ST_PIN] = pin;
    w[rpcbl_pkg::ST_REJECT] = t.cmdReject;
    w[rpcbl_pkg::ST_MODE_LSB +: 2] = t.mode;
    w[rpcbl_pkg::ST_SR_LSB +: 8] = t.lastSr;
    w[rpcbl_pkg::ST_WIDTH_LSB +: 8] = t.pulseWidth;
    return w;
  endfunction

  // Register slave and command sequencer. Each flash step is one pin cycle;
  // the request stays high until the engine reports done.
  always_comb begin
    logic acc;
    logic wr;
    logic start;
    logic launch;
    logic cfg;
    logic [31:0] wd;
    logic [2:0] opf;
    logic [7:0] sr;
    acc = cyc_i && stb_i && !s.ack;
    wr = acc && we_i;
    start = 1'b0;
    launch = 1'b0;
    wd = lanes(dat_i, sel_i);
    opf = wd[rpcbl_pkg::CTRL_OP_LSB +: 3];
    sr = cycBus.rdata[7:0];
    cfg = (s.op == rpcbl_pkg::OP_CFG);
    n = s;
    n.ack = acc;
    n.dat = 32'h0;

    // Every access is answered one cycle later; unmapped reads give zero.
    if (acc && !we_i) begin
      unique case (adr_i)
        rpcbl_pkg::REG_CTRL: n.dat = {16'h0, s.code, 5'h0, s.op};
        rpcbl_pkg::REG_ARG: n.dat = 32'(s.blk);
        rpcbl_pkg::REG_STAT: n.dat = statWord(s, readyStatusPin);
        default: n.dat = 32'h0;
      endcase
    end

    // Write one to clear; the event updates below run later, so set wins.
    if (wr && adr_i == rpcbl_pkg::REG_CLR) begin
      if (wd[rpcbl_pkg::ST_REFUSED]) n.refused = 1'b0;
      if (wd[rpcbl_pkg::ST_PROG_ERR]) n.progErr = 1'b0;
      if (wd[rpcbl_pkg::ST_ERASE_ERR]) n.eraseErr = 1'b0;
      if (wd[rpcbl_pkg::ST_PULSE]) n.pulseSeen = 1'b0;
      if (wd[rpcbl_pkg::ST_REJECT]) n.cmdReject = 1'b0;
    end

    // Orders that arrive mid-operation are dropped and flagged, since a
    // changed block number would split one sequence over two blocks.
    if (wr && adr_i == rpcbl_pkg::REG_ARG) begin
      if (s.st != rpcbl_pkg::S_IDLE) n.cmdReject = 1'b1;
      else n.blk = wd[BLK_W-1:0];
    end
    if (wr && adr_i == rpcbl_pkg::REG_CTRL) begin
      if (s.st != rpcbl_pkg::S_IDLE) n.cmdReject = 1'b1;
      else if (opf != 3'h0 && opf <= 3'(rpcbl_pkg::OP_RESET)) start = 1'b1;
    end

    if (pulseEvt) begin
      n.pulseSeen = 1'b1;
      n.pulseWidth = lowWidth;
    end

    unique case (s.st)
      rpcbl_pkg::S_IDLE: begin
        if (start) begin
          n.op = rpcbl_pkg::rpcbl_op_e'(opf);
          n.code = wd[rpcbl_pkg::CTRL_CODE_LSB +: 8];
          launch = 1'b1;
          unique case (n.op)
            rpcbl_pkg::OP_CFG: n.st = rpcbl_pkg::S_STCMD;
            rpcbl_pkg::OP_QUERY: n.st = rpcbl_pkg::S_IDCMD;
            rpcbl_pkg::OP_RESET: begin
              n.st = rpcbl_pkg::S_RST;
              n.cnt = 8'(rpcbl_pkg::RST_CYC);
              n.rpN = 1'b0;
              launch = 1'b0;
            end
            default: n.st = rpcbl_pkg::S_SETUP;
          endcase
        end
      end
      // A device reset puts the pin back into level mode, so the shadow
      // copy of the mode follows it.
      rpcbl_pkg::S_RST: begin
        n.cnt = s.cnt - 8'h01;
        if (s.cnt == 8'h01) begin
          n.rpN = 1'b1;
          n.mode = 2'b00;
          n.st = rpcbl_pkg::S_IDLE;
        end
      end
      default: begin
        if (s.req && cycBus.done) begin
          n.req = 1'b0;
          launch = 1'b1;
          unique case (s.st)
            rpcbl_pkg::S_STCMD: n.st = rpcbl_pkg::S_STRD;
            // Pin configuration goes ahead only on a ready device.
            rpcbl_pkg::S_STRD: begin
              n.lastSr = sr;
              if (!sr[rpcbl_pkg::SR_READY]) begin
                n.refused = 1'b1;
                n.st = rpcbl_pkg::S_IDLE;
                launch = 1'b0;
              end else begin
                n.st = rpcbl_pkg::S_SETUP;
              end
            end
            rpcbl_pkg::S_SETUP: n.st = rpcbl_pkg::S_CONFIRM;
            rpcbl_pkg::S_CONFIRM: n.st = rpcbl_pkg::S_PLCMD;
            rpcbl_pkg::S_PLCMD: n.st = rpcbl_pkg::S_PLRD;
            // Poll until ready, then collect and clear the error flags.
            rpcbl_pkg::S_PLRD: begin
              n.lastSr = sr;
              if (sr[rpcbl_pkg::SR_READY]) begin
                if (sr[rpcbl_pkg::SR_PROG_ERR]) n.progErr = 1'b1;
                if (sr[rpcbl_pkg::SR_ERASE_ERR]) n.eraseErr = 1'b1;
                if (cfg && !sr[rpcbl_pkg::SR_PROG_ERR]
                    && !sr[rpcbl_pkg::SR_ERASE_ERR])
                  n.mode = s.code[1:0];
                if (sr[rpcbl_pkg::SR_PROG_ERR] || sr[rpcbl_pkg::SR_ERASE_ERR])
                  n.st = rpcbl_pkg::S_CLR;
                else begin
                  n.st = rpcbl_pkg::S_IDLE;
                  launch = 1'b0;
                end
              end
            end
            rpcbl_pkg::S_IDCMD: n.st = rpcbl_pkg::S_IDRD;
            rpcbl_pkg::S_IDRD: begin
              n.locked = cycBus.rdata[0];
              n.st = rpcbl_pkg::S_ARRAY;
            end
            default: begin
              n.st = rpcbl_pkg::S_IDLE;
              launch = 1'b0;
            end
          endcase
        end
      end
    endcase

    // Cycle parameters for the state just entered. Status reads use the
    // block address so that lock operations poll inside their own block.
    if (launch) begin
      n.req = 1'b1;
      n.we = 1'b1;
      n.addr = blkBase(n.blk);
      n.wdata = rpcbl_pkg::CMD_READ_STATUS;
      unique case (n.st)
        rpcbl_pkg::S_STRD, rpcbl_pkg::S_PLRD: n.we = 1'b0;
        // The op register may still hold the previous order on entry from
        // idle, so the setup code follows the op being started.
        rpcbl_pkg::S_SETUP:
          n.wdata = (n.op == rpcbl_pkg::OP_CFG) ? rpcbl_pkg::CMD_STS_CFG
                                                : rpcbl_pkg::CMD_LOCK_SETUP;
        rpcbl_pkg::S_CONFIRM: begin
          if (cfg) n.wdata = {8'h00, s.code};
          else if (s.op == rpcbl_pkg::OP_LOCK)
            n.wdata = rpcbl_pkg::CMD_LOCK_SET;
          else n.wdata = rpcbl_pkg::CMD_LOCK_CLEAR;
        end
        rpcbl_pkg::S_CLR: n.wdata = rpcbl_pkg::CMD_CLEAR_STATUS;
        rpcbl_pkg::S_IDCMD: n.wdata = rpcbl_pkg::CMD_READ_ID;
        rpcbl_pkg::S_IDRD: begin
          n.we = 1'b0;
          n.addr = blkBase(n.blk) + AW'(rpcbl_pkg::LOCK_OFS);
        end
        rpcbl_pkg::S_ARRAY: n.wdata = rpcbl_pkg::CMD_READ_ARRAY;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.rpN <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign cycBus.req = s.req;
  assign cycBus.we = s.we;
  assign cycBus.addr = s.addr;
  assign cycBus.wdata = s.wdata;
  assign dat_o = s.dat;
  assign ack_o = s.ack;
  assign resetPinLowN = s.rpN;

  rpcbl_cyc_engine #(.AW(AW)) u_engine (
    .clk(clk),
    .rstn(rstn),
    .bus(cycBus.engine),
    .dqIn(flashDqIn),
    .addr(flashAddr),
    .dqOut(flashDqOut),
    .dqOe(flashDqOe),
    .ceN(flashCeN),
    .oeN(flashOeN),
    .weN(flashWeN)
  );

  // Pulses count only while the shadow mode says a pulse mode is active.
  rpcbl_sts_mon u_mon (
    .clk(clk),
    .rstn(rstn),
    .readyStatusPin(readyStatusPin),
    .pulseMode(s.mode != 2'b00),
    .pulseEvt(pulseEvt),
    .lowWidth(lowWidth)
  );

  property p_cfgConfirm;
    @(posedge clk) disable iff (!rstn)
      (s.st == rpcbl_pkg::S_SETUP && s.op == rpcbl_pkg::OP_CFG && s.req
       && cycBus.done) |=> (s.req && s.we && s.wdata == {8'h00, s.code});
  endproperty
  a_cfgConfirm: assert property (p_cfgConfirm)
    else $error("Config code did not follow the config setup write.");

  property p_cfgGuard;
    @(posedge clk) disable iff (!rstn)
      (s.st == rpcbl_pkg::S_STRD && s.req && cycBus.done
       && !cycBus.rdata[7]) |=> (s.st == rpcbl_pkg::S_IDLE && s.refused);
  endproperty
  a_cfgGuard: assert property (p_cfgGuard)
    else $error("Config went ahead while the device was not ready.");

  property p_lockConfirm;
    @(posedge clk) disable iff (!rstn)
      (s.st == rpcbl_pkg::S_CONFIRM && s.op == rpcbl_pkg::OP_LOCK && s.req)
      |-> (s.we && s.wdata == 16'h0001 && s.addr == blkBase(s.blk));
  endproperty
  a_lockConfirm: assert property (p_lockConfirm)
    else $error("Lock confirm has the wrong data or block address.");

  property p_unlockSeq;
    @(posedge clk) disable iff (!rstn)
      (s.st == rpcbl_pkg::S_SETUP && s.op == rpcbl_pkg::OP_UNLOCK
       && s.req && cycBus.done)
      |=> (s.wdata == 16'h00D0 && s.we && s.st == rpcbl_pkg::S_CONFIRM);
  endproperty
  a_unlockSeq: assert property (p_unlockSeq)
    else $error("Unlock setup was not followed by the clear confirm.");

  property p_errClear;
    @(posedge clk) disable iff (!rstn)
      (s.st == rpcbl_pkg::S_PLRD && s.req && cycBus.done && cycBus.rdata[7]
       && (cycBus.rdata[4] || cycBus.rdata[5]))
      |=> (s.st == rpcbl_pkg::S_CLR && s.wdata == 16'h0050)
          ##[1:20] (s.st == rpcbl_pkg::S_IDLE);
  endproperty
  a_errClear: assert property (p_errClear)
    else $error("Error flags were not cleared after a failed operation.");

  property p_lockRead;
    @(posedge clk) disable iff (!rstn)
      (s.st == rpcbl_pkg::S_IDRD && s.req)
      |-> (!s.we && s.addr == blkBase(s.blk) + AW'(2));
  endproperty
  a_lockRead: assert property (p_lockRead)
    else $error("Lock state read went to the wrong address.");

  property p_arrayBack;
    @(posedge clk) disable iff (!rstn)
      (s.st == rpcbl_pkg::S_IDRD && s.req && cycBus.done)
      |=> (s.locked == $past(cycBus.rdata[0]) && s.wdata == 16'h00FF)
          ##[1:20] (s.st == rpcbl_pkg::S_IDLE);
  endproperty
  a_arrayBack: assert property (p_arrayBack)
    else $error("Read array did not follow the lock state read.");
endmodule

// ---- hw/rpcbl_pkg.sv ----
package rpcbl_pkg;

  // Register byte offsets on the software bus.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CLR = 8'h0C;

  // Control word fields.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_CODE_LSB = 8;

  // Status word fields; the clear register uses the same positions.
  localparam int ST_BUSY = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_PROG_ERR = 3;
  localparam int ST_ERASE_ERR = 4;
  localparam int ST_PULSE = 5;
  localparam int ST_PIN = 6;
  localparam int ST_REJECT = 7;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_SR_LSB = 16;
  localparam int ST_WIDTH_LSB = 24;

  // Flash command words.
  localparam logic [15:0] CMD_STS_CFG = 16'h00B8;
  localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] CMD_LOCK_SET = 16'h0001;
  localparam logic [15:0] CMD_LOCK_CLEAR = 16'h00D0;
  localparam logic [15:0] CMD_READ_ID = 16'h0090;
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;

  // Flash status bits and the lock state word offset.
  localparam int SR_READY = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int LOCK_OFS = 2;

  // Pin timing in ns and the derived cycle counts, least times rounded up.
  localparam int CLK_NS = 25;
  localparam int T_WE_NS = 50;
  localparam int T_RD_NS = 100;
  localparam int T_RST_NS = 1000;
  localparam int WE_CYC = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    OP_NONE, OP_CFG, OP_LOCK, OP_UNLOCK, OP_QUERY, OP_RESET
  } rpcbl_op_e;

  typedef enum logic [3:0] {
    S_IDLE, S_RST, S_STCMD, S_STRD, S_SETUP, S_CONFIRM, S_PLCMD,
    S_PLRD, S_CLR, S_IDCMD, S_IDRD, S_ARRAY
  } rpcbl_st_e;

  typedef enum logic [1:0] {E_IDLE, E_SET, E_STB, E_HOLD} rpcbl_eng_e;
endpackage

// ---- hw/rpcbl_sts_mon.sv ----
module rpcbl_sts_mon (
  input wire logic clk,
  input wire logic rstn,
  input wire logic readyStatusPin,
  input wire logic pulseMode,
  output logic pulseEvt,
  output logic [7:0] lowWidth
);
  typedef struct packed {
    logic prev;
    logic [7:0] cnt;
    logic evt;
    logic [7:0] width;
  } rpcbl_mon_s;

  rpcbl_mon_s s;
  rpcbl_mon_s n;

  // A rising pin after a low stretch is a completion pulse only in pulse
  // mode; in level mode the same edge just means the device went ready.
  always_comb begin
    n = s;
    n.prev = readyStatusPin;
    n.evt = 1'b0;
    if (!readyStatusPin) begin
      if (s.cnt != 8'hFF) n.cnt = s.cnt + 8'h01;
    end else begin
      n.cnt = 8'h00;
      if (!s.prev && pulseMode) begin
        n.evt = 1'b1;
        n.width = s.cnt;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.prev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign pulseEvt = s.evt;
  assign lowWidth = s.width;
endmodule

// ---- tb/rpcbl_flash_model.sv ----
module rpcbl_flash_model (
  input wire logic clk,
  input wire logic [22:0] addr,
  input wire logic [15:0] dqHost,
  input wire logic dqOe,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic resetPinLowN,
  input wire logic eraseGo,
  input wire logic vpenLow,
  output logic [15:0] dqWire,
  output logic readyStatusPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] lockBits = '0;
  logic [1:0] stsMode = 2'h0;
  logic [6:0] sr = 7'h00;
  logic [15:0] setup = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [15:0] rd;
  int busyCnt = 0;
  int pulseCnt = 0;
  int rdMode = 0;
  bit eraseRun = 0;

  // Commands latch on the rising write strobe while the chip is selected.
  // All updates are non-blocking, so the host samples settled pins only.
  always @(posedge weN) begin
    if (!ceN && resetPinLowN) begin
      if (setup == 16'h00B8) begin
        if (busyCnt == 0 && dqHost[1:0] == 2'h2) begin
          sr[5:4] <= 2'h3;
        end else if (busyCnt == 0) begin
          stsMode <= dqHost[1:0];
        end
        setup <= 16'h0000;
      end else if (setup == 16'h0060) begin
        if (vpenLow || busyCnt != 0) begin
          sr[dqHost == 16'h0001 ? 4 : 5] <= 1'b1;
        end else if (dqHost == 16'h0001) begin
          lockBits[addr[22:16]] <= 1'b1;
        end else if (dqHost == 16'h00D0) begin
          lockBits <= '0;
        end
        busyCnt <= 12;
        setup <= 16'h0000;
      end else begin
        setup <= dqHost;
        if (dqHost == 16'h0060 || dqHost == 16'h0070) rdMode <= 1;
        if (dqHost == 16'h0090) rdMode <= 2;
        if (dqHost == 16'h00FF) rdMode <= 0;
        if (dqHost == 16'h0050) sr[5:4] <= 2'h0;
      end
    end
  end

  // Internal timing; lock work never arms a pulse, only a finished erase.
  // The outside erase always aims at block 0 and is dropped while locked.
  always @(posedge clk) begin
    last <= dqWire;
    if (!resetPinLowN) begin
      stsMode <= 2'h0;
      setup <= 16'h0000;
      rdMode <= 0;
      sr <= 7'h00;
      busyCnt <= 0;
    end else if (eraseGo && !lockBits[0]) begin
      busyCnt <= 150;
      eraseRun <= 1'b1;
    end else if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
      if (busyCnt == 1 && eraseRun && stsMode[0]) pulseCnt <= 20;
      if (busyCnt == 1) eraseRun <= 1'b0;
    end else if (pulseCnt > 0) begin
      pulseCnt <= pulseCnt - 1;
    end
  end

  // Ready flag is zero while busy; a released bus shows the inverse level.
  assign rd = rdMode == 1 ? {8'h00, busyCnt == 0, sr} :
    rdMode == 2 ? {15'h0000, addr[15:0] == 16'h2 && lockBits[addr[22:16]]} :
    16'hFFFF;
  assign dqWire = dqOe ? dqHost : (!ceN && !oeN) ? rd : ~last;
  assign readyStatusPin = stsMode == 2'h0 ? busyCnt == 0
                                          : pulseCnt == 0;
endmodule

// ---- tb/rpcbl_host_tb.sv ----
module rpcbl_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, cyc, stb, we, ack, fDqOe, ceN, oeN, weN, rpN, pin;
  logic eraseGo, vpenLow;
  logic [7:0] adr;
  logic [31:0] dat, datO, q;
  logic [3:0] sel;
  logic [22:0] fAddr;
  logic [15:0] fDqOut, dqWire;
  logic [127:0] lockRef;
  logic [6:0] blk;
  logic [7:0] codes[$] = '{8'h01, 8'h02, 8'hFF, 8'hFD, 8'h00};
  int errors, checked, seed, expMode;

  rpcbl_host dut (.clk(clk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(datO),
    .ack_o(ack), .flashAddr(fAddr), .flashDqIn(dqWire),
    .flashDqOut(fDqOut), .flashDqOe(fDqOe), .flashCeN(ceN),
    .flashOeN(oeN), .flashWeN(weN), .resetPinLowN(rpN),
    .readyStatusPin(pin));
  rpcbl_flash_model fm (.clk(clk), .addr(fAddr), .dqHost(fDqOut),
    .dqOe(fDqOe), .ceN(ceN), .oeN(oeN), .weN(weN), .resetPinLowN(rpN),
    .eraseGo(eraseGo), .vpenLow(vpenLow), .dqWire(dqWire),
    .readyStatusPin(pin));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      errors++;
      wrap_up();
    end
  endtask

  // Starts an operation and polls until the controller is idle again.
  task automatic run(input logic [2:0] op, input logic [7:0] code,
                     input logic [6:0] b, output logic [31:0] st);
    int n;
    n = 0;
    wb(1'b1, 8'h04, {25'h0, b}, st);
    wb(1'b1, 8'h00, {16'h0, code, 5'h00, op}, st);
    do begin
      wb(1'b0, 8'h08, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      errors++;
      wrap_up();
    end
  endtask

  // Another bus master starts a long erase inside the device.
  task automatic kick;
    eraseGo <= 1'b1;
    @(posedge clk);
    eraseGo <= 1'b0;
  endtask

  initial begin
    seed = 73899;
    rstn = 1'b0;
    {cyc, stb, we, eraseGo, vpenLow} = 5'h00;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'hF;
    lockRef = '0;
    expMode = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, 8'h08, 32'h0, q);
    chk("mode", 0, q[9:8]);
    chk("pin", 1, q[6]);
    wb(1'b0, 8'h10, 32'h0, q);
    chk("unmapped", 0, q);
    $display("test reset done");
    kick();
    wb(1'b0, 8'h08, 32'h0, q);
    chk("busy pin", 0, q[6]);
    run(3'h1, 8'h01, 7'h00, q);
    chk("refused", 1, q[2]);
    chk("device mode", 0, fm.stsMode);
    repeat (200) @(posedge clk);
    wb(1'b1, 8'h0C, 32'hBC, q);
    $display("test busy refusal done");
    foreach (codes[i]) begin
      run(3'h1, codes[i], 7'h00, q);
      if (codes[i][1:0] != 2'h2) expMode = codes[i][1:0];
      chk("errors", {2{codes[i][1:0] == 2'h2}}, q[4:3]);
      chk("mode", expMode, q[9:8]);
      chk("device mode", expMode, fm.stsMode);
      kick();
      repeat (200) @(posedge clk);
      wb(1'b0, 8'h08, 32'h0, q);
      chk("pulse", expMode != 0, q[5]);
      if (expMode != 0) chk("width", 1, q[31:24] inside {[19:21]});
      wb(1'b1, 8'h0C, 32'hBC, q);
      $display("test config code %h done", codes[i]);
    end
    run(3'h1, 8'h01, 7'h00, q);
    blk = 7'($random(seed));
    run(3'h2, 8'h00, blk, q);
    lockRef[blk] = 1'b1;
    chk("lock errors", 0, q[4:3]);
    chk("lock pulse", 0, q[5]);
    run(3'h4, 8'h00, blk, q);
    chk("locked", lockRef[blk], q[1]);
    run(3'h4, 8'h00, blk + 7'h1, q);
    chk("neighbour", lockRef[blk + 7'h1], q[1]);
    run(3'h5, 8'h00, 7'h00, q);
    chk("device mode", 0, fm.stsMode);
    run(3'h4, 8'h00, blk, q);
    chk("kept lock", lockRef[blk], q[1]);
    run(3'h2, 8'h00, 7'h00, q);
    lockRef[0] = 1'b1;
    kick();
    wb(1'b0, 8'h08, 32'h0, q);
    chk("locked erase pin", 1, q[6]);
    $display("test lock and reset done");
    vpenLow <= 1'b1;
    run(3'h2, 8'h00, blk + 7'h1, q);
    chk("set fail", 1, q[4:3]);
    run(3'h3, 8'h00, 7'h00, q);
    chk("clear fail", 3, q[4:3]);
    run(3'h4, 8'h00, blk, q);
    chk("still locked", lockRef[blk], q[1]);
    vpenLow <= 1'b0;
    wb(1'b1, 8'h0C, 32'hBC, q);
    run(3'h3, 8'h00, 7'h00, q);
    lockRef = '0;
    run(3'h4, 8'h00, blk, q);
    chk("unlocked", lockRef[blk], q[1]);
    $display("test lock failure done");
    wb(1'b1, 8'h00, 32'h4, q);
    wb(1'b1, 8'h00, 32'h4, q);
    run(3'h0, 8'h00, 7'h00, q);
    chk("rejected", 1, q[7]);
    $display("test busy order done");
    wrap_up();
  end
endmodule
